// ### src/node_pkg.sv
// Shared constants, states and carriers of the bus I/O node.
package node_pkg;

    // ------------------------------------------------------------
    // Widths and layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 4;
    localparam int CH_W = 4;
    localparam int GRAY_W = 4;
    localparam int IDLE_W = 8;
    localparam int DEB_W = 2;
    localparam int FIFO_DEPTH = 8;
    localparam logic [IDX_W-1:0] LAST_BIT = 4'hf;
    localparam logic [CH_W-1:0] CH_LAST = 4'hf;
    localparam logic [CH_W-1:0] CH_FIRST = 4'h0;

    // ------------------------------------------------------------
    // Timing, in core clock cycles derived from nanoseconds, and debounce frame counts
    // ------------------------------------------------------------
    localparam int CORE_NS = 100;
    localparam int SYNC_IDLE_NS = 100;
    localparam int SYNC_IDLE_RAW = SYNC_IDLE_NS / CORE_NS;
    localparam int SYNC_IDLE_CYC = (SYNC_IDLE_RAW < 1) ? 1 : SYNC_IDLE_RAW;
    localparam int LOSS_NS = 10000;
    localparam int LOSS_CYC = LOSS_NS / CORE_NS;
    localparam logic [IDLE_W-1:0] SYNC_IDLE_CNT = IDLE_W'(SYNC_IDLE_CYC);
    localparam logic [IDLE_W-1:0] LOSS_CNT = IDLE_W'(LOSS_CYC);
    localparam logic [DEB_W-1:0] DEB_FRAMES = 2'h3;
    localparam logic [DEB_W-1:0] DEB_FIRST = 2'h1;

    // ------------------------------------------------------------
    // Output values before the bus runs and after it halts
    // ------------------------------------------------------------
    localparam logic [WORD_W-1:0] SHELF_VAL = 16'h0000;
    localparam logic [WORD_W-1:0] DEFAULT_VAL = 16'h0000;

    typedef enum logic [2:0] {
        ST_SHELF = 3'b001,
        ST_RUN = 3'b010,
        ST_HALT = 3'b100
    } node_st_t;

    typedef struct packed {
        logic ms_mode;
        logic mux_en;
        logic [CH_W-1:0] chan;
        logic [IDX_W-1:0] in_word;
        logic [IDX_W-1:0] out_word;
    } cfg_t;

    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic [WORD_W-1:0] bits;
    } rx_word_t;

endpackage : node_pkg

// ### src/sync2.sv
// Two-flop synchroniser for levels, toggles and gray codes.
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : sync2

// ### src/word_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Full and empty come straight from the fill count.
    assign in_ready = (cnt_r != FULL_CNT);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap at the depth, which need not be a power of two.
    always_comb
    begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            wr_nxt = (wr_r == PTR_LAST) ? '0 : PW'(wr_r + 1'b1);
        end
        if (pop)
        begin
            rd_nxt = (rd_r == PTR_LAST) ? '0 : PW'(rd_r + 1'b1);
        end
        if (push && !pop)
        begin
            cnt_nxt = (PW+1)'(cnt_r + 1'b1);
        end
        else if (pop && !push)
        begin
            cnt_nxt = (PW+1)'(cnt_r - 1'b1);
        end
    end

    // Pointers and count.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage has no reset; only filled entries are ever read.
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

endmodule : word_fifo

// ### src/bus_node.sv
// Slave I/O node: frame addressing, sync, word exchange and output state.
//
// Functional notes
// [RULE_01] Peer mode: one pulse, joint sampling.
// [RULE_02] Sync pause resets the address counter.
// [RULE_03] Source makes pause 8+ periods.
// [RULE_04] Multi-bit signal starts at its LSB address.
// [RULE_05] Words are 16 bits at multiples of 16.
// [RULE_06] Numeric values sit inside aligned words.
// [RULE_07] Shared input address reads as wired-OR.
// [RULE_08] Shared output address switches all nodes.
// [RULE_09] Shelf state before run, default after halt.
// [RULE_10] Multiplexed update period spans scanned channels.
// [RULE_11] Slave never drives the bus clock.
// [RULE_12] Master/slave: input pulse then output pulse.
// [RULE_13] Outputs change after repeated identical frames.
// [RULE_14] High line means 0, low means 1.
// [RULE_15] Multiplex channel 0 to 15 extends address.
// [RULE_16] Address advances once per slot.
// [RULE_17] Sync declared after idle below minimum; the node declares it after SYNC_IDLE_CNT quiet core cycles.
`timescale 1ns/1ps
module bus_node
    import node_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic bus_clk,
    input wire logic dat_in,
    output logic dat_out,
    output logic dat_oe,
    output logic clk_out,
    output logic clk_oe,
    input wire node_pkg::cfg_t cfg,
    input wire logic [node_pkg::WORD_W-1:0] in_bits,
    output logic [node_pkg::WORD_W-1:0] out_bits,
    output node_pkg::node_st_t bus_st,
    output node_pkg::rx_word_t rx_word,
    output logic rx_valid,
    input wire logic rx_ready
);
    import node_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic clr_r, clr_nxt, lrst_n;
    logic [11:0] l_q;
    logic [5:0] c_q;
    logic l_ms, l_drv, l_txt, l_rxa, c_rxt, c_txa;
    logic [IDX_W-1:0] l_in_w, l_out_w;
    logic [GRAY_W-1:0] pg_s, pg_prev_r, pbin_r, pbin_nxt, pgray_r, pgray_nxt;
    logic tx_ack_r, tx_ack_nxt, rx_tog_r, rx_tog_nxt;
    logic [WORD_W-1:0] tx_bits_r, tx_bits_nxt, rx_hold_r, rx_hold_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt, addr_prev_r;
    logic phase_r, phase_nxt, dat_oe_r, dat_oe_nxt;
    logic [WORD_W-1:0] rx_sh_r, rx_sh_nxt;
    logic bit_val, slot_out, nslot_in, in_out_word, word_done;
    logic act, seen_r, seen_nxt, sync_fire, mine, pend, push_v, f_rdy;
    logic [IDLE_W-1:0] idle_r, idle_nxt;
    logic [CH_W-1:0] fch_r, fch_nxt, fch_inc;
    logic drv_en_r, drv_en_nxt, rx_ack_r, rx_ack_nxt, tx_tog_r, tx_tog_nxt;
    logic [WORD_W-1:0] tx_hold_r, tx_hold_nxt, cand_r, cand_nxt, deb_r, deb_nxt;
    logic [WORD_W-1:0] out_nxt;
    logic [DEB_W-1:0] dcnt_r, dcnt_nxt;
    node_st_t st_r, st_nxt;

    // ------------------------------------------------------------
    // Pins and crossings
    // ------------------------------------------------------------
    // The data line is open drain: the node only ever pulls it low.
    assign dat_out = 1'b0;
    assign dat_oe = dat_oe_r;
    assign clk_out = 1'b0;
    assign clk_oe = 1'b0; // RULE_11
    assign bus_st = st_r;
    // Address state is cleared while the bus clock stands in a pause.
    assign lrst_n = nrst && !clr_r; // RULE_02

    sync2 #(.WIDTH(12)) l_sync (
        .clk(bus_clk),
        .rst_n(nrst),
        .d({cfg.ms_mode, cfg.in_word, cfg.out_word, drv_en_r, tx_tog_r, rx_ack_r}),
        .q(l_q)
    );
    assign {l_ms, l_in_w, l_out_w, l_drv, l_txt, l_rxa} = l_q;

    sync2 #(.WIDTH(6)) c_sync (
        .clk(core_clk),
        .rst_n(nrst),
        .d({pgray_r, rx_tog_r, tx_ack_r}),
        .q(c_q)
    );
    assign {pg_s, c_rxt, c_txa} = c_q;

    // ------------------------------------------------------------
    // Link domain: slots, sampling and driving
    // ------------------------------------------------------------
    // A low line is value 1; in peer mode sampling and driving share each slot, in master/slave mode they use alternate pulses.
    always_comb
    begin
        bit_val = !dat_in; // RULE_14
        slot_out = !l_ms || phase_r; // RULE_12
        in_out_word = slot_out && (addr_r[ADDR_W-1:IDX_W] == l_out_w); // RULE_05
        word_done = in_out_word && (addr_r[IDX_W-1:0] == LAST_BIT);
        pbin_nxt = GRAY_W'(pbin_r + 1'b1);
        pgray_nxt = pbin_nxt ^ (pbin_nxt >> 1);
        tx_bits_nxt = tx_bits_r;
        tx_ack_nxt = tx_ack_r;
        if (l_txt != tx_ack_r)
        begin
            tx_bits_nxt = tx_hold_r;
            tx_ack_nxt = !tx_ack_r;
        end
        rx_sh_nxt = rx_sh_r;
        if (in_out_word)
        begin
            rx_sh_nxt[addr_r[IDX_W-1:0]] = bit_val; // RULE_04 RULE_08
        end
        rx_hold_nxt = rx_hold_r;
        rx_tog_nxt = rx_tog_r;
        if (word_done && (rx_tog_r == l_rxa))
        begin
            rx_hold_nxt = rx_sh_nxt;
            rx_tog_nxt = !rx_tog_r;
        end
        if (l_ms)
        begin
            phase_nxt = !phase_r; // RULE_12
            addr_nxt = phase_r ? ADDR_W'(addr_r + 1'b1) : addr_r; // RULE_16
        end
        else
        begin
            phase_nxt = 1'b0;
            addr_nxt = ADDR_W'(addr_r + 1'b1); // RULE_01 RULE_16
        end
        nslot_in = !l_ms || !phase_nxt;
        dat_oe_nxt = l_drv && nslot_in && (addr_nxt[ADDR_W-1:IDX_W] == l_in_w)
            && tx_bits_nxt[addr_nxt[IDX_W-1:0]]; // RULE_07
    end

    // Pulse count and handshakes keep running across sync pauses.
    always_ff @(posedge bus_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pbin_r <= '0;
            pgray_r <= '0;
            tx_bits_r <= '0;
            tx_ack_r <= 1'b0;
            rx_hold_r <= '0;
            rx_tog_r <= 1'b0;
        end
        else
        begin
            pbin_r <= pbin_nxt;
            pgray_r <= pgray_nxt;
            tx_bits_r <= tx_bits_nxt;
            tx_ack_r <= tx_ack_nxt;
            rx_hold_r <= rx_hold_nxt;
            rx_tog_r <= rx_tog_nxt;
        end
    end

    // Address, phase, word shifter and drive restart at each sync.
    always_ff @(posedge bus_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            addr_r <= '0; // RULE_02
            addr_prev_r <= '1; // One below zero, so the first step after a sync holds.
            phase_r <= 1'b0;
            rx_sh_r <= '0;
            dat_oe_r <= 1'b0;
        end
        else
        begin
            addr_r <= addr_nxt;
            addr_prev_r <= addr_r;
            phase_r <= phase_nxt;
            rx_sh_r <= rx_sh_nxt;
            dat_oe_r <= dat_oe_nxt;
        end
    end

    // ------------------------------------------------------------
    // Core domain: sync, run state, debounce and word traffic
    // ------------------------------------------------------------
    assign act = (pg_s != pg_prev_r);
    assign pend = (c_rxt != rx_ack_r);
    assign mine = !cfg.mux_en || (fch_r == cfg.chan); // RULE_15
    assign push_v = pend && mine;
    assign fch_inc = (fch_r == CH_LAST) ? CH_FIRST : CH_W'(fch_r + 1'b1);
    // A quiet pulse count for the threshold marks the frame end.
    assign sync_fire = !act && seen_r && (idle_r == SYNC_IDLE_CNT - 1'b1); // RULE_17 RULE_03

    always_comb
    begin
        idle_nxt = act ? '0 : ((idle_r == LOSS_CNT) ? idle_r : IDLE_W'(idle_r + 1'b1));
        seen_nxt = sync_fire ? 1'b0 : (seen_r || act);
        clr_nxt = sync_fire; // RULE_02
        fch_nxt = fch_r;
        drv_en_nxt = drv_en_r;
        st_nxt = st_r;
        unique case (st_r)
            ST_SHELF, ST_HALT:
            begin
                if (sync_fire)
                begin
                    st_nxt = ST_RUN;
                    fch_nxt = CH_FIRST;
                    drv_en_nxt = !cfg.mux_en || (cfg.chan == CH_FIRST);
                end
            end
            ST_RUN:
            begin
                if (idle_r == LOSS_CNT)
                begin
                    st_nxt = ST_HALT;
                    drv_en_nxt = 1'b0;
                end
                else if (sync_fire)
                begin
                    fch_nxt = fch_inc; // RULE_10
                    drv_en_nxt = !cfg.mux_en || (cfg.chan == fch_inc); // RULE_15
                end
            end
        endcase
        rx_ack_nxt = rx_ack_r;
        if ((push_v && f_rdy) || (pend && !mine))
        begin
            rx_ack_nxt = !rx_ack_r;
        end
        cand_nxt = cand_r;
        dcnt_nxt = dcnt_r;
        deb_nxt = deb_r;
        if (st_r != ST_RUN)
        begin
            dcnt_nxt = '0;
            deb_nxt = SHELF_VAL;
        end
        else if (push_v && f_rdy)
        begin
            if (rx_hold_r == cand_r)
            begin
                dcnt_nxt = (dcnt_r == DEB_FRAMES) ? dcnt_r : DEB_W'(dcnt_r + 1'b1);
            end
            else
            begin
                cand_nxt = rx_hold_r;
                dcnt_nxt = DEB_FIRST;
            end
            if (dcnt_nxt == DEB_FRAMES)
            begin
                deb_nxt = rx_hold_r; // RULE_13
            end
        end
        unique case (st_r)
            ST_SHELF: out_nxt = SHELF_VAL; // RULE_09
            ST_RUN: out_nxt = deb_r; // RULE_06
            ST_HALT: out_nxt = DEFAULT_VAL; // RULE_09
        endcase
        tx_hold_nxt = tx_hold_r;
        tx_tog_nxt = tx_tog_r;
        if (c_txa == tx_tog_r)
        begin
            tx_hold_nxt = in_bits;
            tx_tog_nxt = !tx_tog_r;
        end
    end

    // Core registers.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pg_prev_r <= '0;
            idle_r <= '0;
            seen_r <= 1'b0;
            clr_r <= 1'b0;
            fch_r <= CH_FIRST;
            drv_en_r <= 1'b0;
            st_r <= ST_SHELF;
            rx_ack_r <= 1'b0;
            cand_r <= SHELF_VAL;
            dcnt_r <= '0;
            deb_r <= SHELF_VAL;
            out_bits <= SHELF_VAL;
            tx_hold_r <= '0;
            tx_tog_r <= 1'b0;
        end
        else
        begin
            pg_prev_r <= pg_s;
            idle_r <= idle_nxt;
            seen_r <= seen_nxt;
            clr_r <= clr_nxt;
            fch_r <= fch_nxt;
            drv_en_r <= drv_en_nxt;
            st_r <= st_nxt;
            rx_ack_r <= rx_ack_nxt;
            cand_r <= cand_nxt;
            dcnt_r <= dcnt_nxt;
            deb_r <= deb_nxt;
            out_bits <= out_nxt;
            tx_hold_r <= tx_hold_nxt;
            tx_tog_r <= tx_tog_nxt;
        end
    end

    // Received words wait here; a stalled reader holds the link ack.
    word_fifo #(.WIDTH($bits(rx_word_t)), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .clk(core_clk),
        .nrst(nrst),
        .in_data({fch_r, rx_hold_r}),
        .in_valid(push_v),
        .in_ready(f_rdy),
        .out_data(rx_word),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    clr_after_idle_a: assert property (clr_r |-> idle_r == SYNC_IDLE_CNT && !act) // RULE_17
        else $error("sync clear without quiet threshold");
    clr_single_a: assert property (clr_r |=> !clr_r) // RULE_02
        else $error("sync clear longer than one cycle");
    shelf_out_a: assert property ((st_r == ST_SHELF)[*2] |-> out_bits == SHELF_VAL) // RULE_09
        else $error("outputs left shelf state early");
    halt_out_a: assert property ((st_r == ST_HALT)[*2] |-> out_bits == DEFAULT_VAL) // RULE_09
        else $error("outputs not at default after halt");
    halt_entry_a: assert property ($rose(st_r == ST_HALT) |-> $past(idle_r) == LOSS_CNT) // RULE_09
        else $error("halt without clock loss time");
    deb_change_a: assert property ($changed(deb_r) && st_r == ST_RUN // RULE_13
        |-> dcnt_r == DEB_FRAMES)
        else $error("debounced value changed too soon");
    no_clk_drive_a: assert property (!clk_oe) // RULE_11
        else $error("slave drove the bus clock");
    // The previous address is reset with the address, to one below zero, so a sync does not look like a jump.
    peer_addr_a: assert property (@(posedge bus_clk) disable iff (!lrst_n) // RULE_01
        !l_ms && $past(!l_ms) |-> addr_r == ADDR_W'(addr_prev_r + 1'b1))
        else $error("peer mode address did not step per pulse");
    ms_pair_a: assert property (@(posedge bus_clk) disable iff (!lrst_n) // RULE_12
        l_ms && $past(l_ms) |-> phase_r != $past(phase_r))
        else $error("master/slave phase did not alternate");
    drive_bit_a: assert property (@(posedge bus_clk) disable iff (!lrst_n) // RULE_07
        dat_oe_r |-> addr_r[ADDR_W-1:IDX_W] == l_in_w && tx_bits_r[addr_r[IDX_W-1:0]])
        else $error("line driven outside an own set input bit");

    sync_seen_c: cover property (clr_r && st_r == ST_RUN);
    halt_seen_c: cover property ($rose(st_r == ST_HALT));
    fifo_full_c: cover property (push_v && !f_rdy);
    deb_update_c: cover property ($changed(deb_r) && st_r == ST_RUN);

endmodule : bus_node

// ### verif/bus_clk_source.sv
// Bus clock source and host model that frames the link for the node.
`timescale 1ns/1ps
module bus_clk_source (
    output logic bus_clk,
    output logic src_pull,
    input wire logic dat_line
);
    localparam int HALF_NS = 24;
    localparam int PAUSE_PER = 12;
    logic [255:0] cap;

    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    // Clock rests low and the data line is left to its pull-up.
    initial
    begin
        bus_clk = 1'b0;
        src_pull = 1'b0;
        cap = '0;
    end

    // One pulse: pull after the fall, sample just before the rise.
    task automatic pulse(input logic pull, input int a);
        src_pull = pull;
        #(HALF_NS - 1);
        if (a >= 0)
            cap[a] = ~dat_line;
        #1 bus_clk = 1'b1;
        #HALF_NS bus_clk = 1'b0;
    endtask : pulse

    // One frame of n addresses, then the sync pause with the clock still.
    task automatic run_frame(input int n, input logic ms, input logic [255:0] pat);
        for (int a = 0; a < n; a++)
        begin
            if (ms)
            begin
                pulse(1'b0, a);
                pulse(pat[a], -1);
            end
            else
                pulse(pat[a], a);
        end
        src_pull = 1'b0;
        #(PAUSE_PER * 2 * HALF_NS);
    endtask : run_frame
endmodule : bus_clk_source

// ### verif/clocked_io_bus_node_framing_bench.sv
// Self-checking testbench of the bus I/O node.
`timescale 1ns/1ps
module clocked_io_bus_node_framing_bench;
    import node_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    cfg_t cfg = '0;
    logic [WORD_W-1:0] in_bits = '0;
    logic rx_ready = 1'b0;
    logic bus_clk, src_pull, dat_out, dat_oe, clk_out, clk_oe, rx_valid;
    logic [WORD_W-1:0] out_bits;
    node_st_t bus_st;
    rx_word_t rx_word;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    // Open-drain data line: low while any party pulls it.
    wire logic dat_line = ~(dat_oe | src_pull);

    bus_node bus_node_inst (
        .core_clk(core_clk), .nrst(nrst), .bus_clk(bus_clk), .dat_in(dat_line),
        .dat_out(dat_out), .dat_oe(dat_oe), .clk_out(clk_out), .clk_oe(clk_oe),
        .cfg(cfg), .in_bits(in_bits), .out_bits(out_bits), .bus_st(bus_st),
        .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready)
    );
    bus_clk_source src_inst (.bus_clk(bus_clk), .src_pull(src_pull), .dat_line(dat_line));

    // ------------------------------------------------------------
    // Clock, watchdog and checking helpers
    // ------------------------------------------------------------
    // Core clock at 10 MHz.
    always #50 core_clk = ~core_clk;

    // Cuts a hung run short.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            $display("BAD t=%0t cycles=%h limit=%h", $time, cycles, 3000);
            stop_test();
        end
    end

    // The node must leave the clock line alone at every pulse.
    always @(posedge bus_clk)
        check({clk_oe, clk_out, dat_out}, 32'h0);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    task automatic frame(input int n, input logic ms, input logic [255:0] pat);
        src_inst.run_frame(n, ms, pat);
        repeat (2) @(negedge core_clk);
    endtask : frame

    task automatic pop(input logic [WORD_W-1:0] exp);
        check(rx_valid, 32'h1);
        check(rx_word.bits, exp);
        rx_ready = 1'b1;
        @(negedge core_clk);
        rx_ready = 1'b0;
    endtask : pop

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset with a new setup, check shelf state, then start the bus.
    task automatic start(input cfg_t c, input logic [WORD_W-1:0] ib);
        @(negedge core_clk);
        nrst = 1'b0;
        cfg = c;
        in_bits = ib;
        src_inst.run_frame(2, 1'b0, '0);
        @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        check(bus_st, ST_SHELF);
        check(out_bits, SHELF_VAL);
        check({dat_oe, rx_valid}, 32'h0);
        frame(2, 1'b0, '0);
        check(bus_st, ST_RUN);
        $display("test start done");
    endtask : start

    // Peer frame: receive word 0, drive word 1 wired with the host.
    task automatic test_peer();
        logic [255:0] pat = '0;
        pat[31:0] = 32'h0180_3c5a;
        frame(32, 1'b0, pat);
        check(src_inst.cap[31:16], 16'h8181);
        check(src_inst.cap[15:0], 16'h3c5a);
        pop(16'h3c5a);
        check(rx_valid, 32'h0);
        $display("test peer done");
    endtask : test_peer

    // Outputs move only on the third identical frame.
    task automatic test_debounce();
        logic [255:0] pat = '0;
        pat[15:0] = 16'h9009;
        repeat (2)
        begin
            frame(32, 1'b0, pat);
            pop(16'h9009);
        end
        check(out_bits, 16'h0000);
        frame(32, 1'b0, pat);
        pop(16'h9009);
        check(out_bits, 16'h9009);
        $display("test debounce done");
    endtask : test_debounce

    // Fill the buffer past full with the reader stalled, then drain it.
    task automatic test_fifo();
        logic [255:0] pat = '0;
        int k = 0;
        for (int i = 0; i < 10; i++)
        begin
            pat[15:0] = 16'h0a00 + 16'(i);
            frame(32, 1'b0, pat);
        end
        rx_ready = 1'b1;
        for (int c = 0; c < 30; c++)
        begin
            if (rx_valid === 1'b1)
            begin
                check(rx_word.bits, 16'h0a00 + 16'(k));
                k++;
            end
            @(negedge core_clk);
        end
        rx_ready = 1'b0;
        check(k, 9);
        $display("test fifo done");
    endtask : test_fifo

    // Clock loss halts the node and outputs take the default value.
    // A fresh frame first, so the quiet time is counted from a known point.
    task automatic test_halt();
        logic [255:0] pat = '0;
        pat[15:0] = 16'h9009;
        frame(32, 1'b0, pat);
        pop(16'h9009);
        repeat (LOSS_CYC - 20) @(negedge core_clk);
        check(out_bits, 16'h9009);
        repeat (40) @(negedge core_clk);
        check(bus_st, ST_HALT);
        check(out_bits, DEFAULT_VAL);
        $display("test halt done");
    endtask : test_halt

    // Master/slave: node answers on the first pulse, host writes on the second.
    task automatic test_ms();
        logic [255:0] pat = '0;
        pat[31:16] = 16'hbeef;
        start('{1'b1, 1'b0, 4'h0, 4'h2, 4'h1}, 16'h4321);
        frame(48, 1'b1, pat);
        check(src_inst.cap[47:32], 16'h4321);
        check(src_inst.cap[31:16], 16'h0000);
        pop(16'hbeef);
        $display("test ms done");
    endtask : test_ms

    // Multiplexed node joins only frames of its own channel.
    task automatic test_mux();
        logic [255:0] pat = '0;
        start('{1'b0, 1'b1, 4'h1, 4'h1, 4'h0}, 16'h00ff);
        pat[15:0] = 16'h1111;
        frame(32, 1'b0, pat);
        check(rx_valid, 32'h0);
        check(src_inst.cap[31:16], 16'h0000);
        pat[15:0] = 16'h2222;
        frame(32, 1'b0, pat);
        check(rx_word.chan, 4'h1);
        check(src_inst.cap[31:16], 16'h00ff);
        pop(16'h2222);
        $display("test mux done");
    endtask : test_mux

    // Main sequence.
    initial
    begin
        start('{1'b0, 1'b0, 4'h0, 4'h1, 4'h0}, 16'h8001);
        test_peer();
        test_debounce();
        test_fifo();
        test_halt();
        test_ms();
        test_mux();
        stop_test();
    end
endmodule : clocked_io_bus_node_framing_bench
